// ==== hw/panel_nav.sv ====
// front panel navigator: two keys, four-digit display, self-test, timeout
// assumes key levels synchronous to mclk; power-up drives sys_rst
//
// Behaviour
// - two keys: advance/clear and select
// - both keys together store edited value
// - four digits: red code, three green values
// - indicator mode lights red digit only in main menu and edit
// - fifteen second segment self-test, then dark
// - outer segments clockwise, then centre segments
// - sweep runs twice
// - advance key aborts self-test
// - one second hold steps forward
// - half second press steps backward
// - dark position allows only forward
// - held key repeats, pausing at dark
// - five minutes idle blanks display
// - one second select enters submenu
// - red digit flashes after select release
// - submenu uses same stepping; dark red exits
// - value LED stays lit in submenu
// - submenu shows flashing red with green digits lit
// - store only within limits, else keep
`timescale 1ns/1ps
`include "panel_params.svh"

module panel_nav #(
    parameter int TICK_CYC   = `TICK_CYCLES,
    parameter int IDLE_TICKS = `IDLE_TIMEOUT_TICKS,
    parameter int STEP_TICKS = `SELFTEST_STEP_TICKS,
    parameter int PAUSE_TICKS= `DARK_PAUSE_TICKS,
    parameter int MAIN_N     = `MAIN_ITEMS,
    parameter int SUB_N      = `SUB_ITEMS
) (
    input  wire logic        mclk,        // module clock
    input  wire logic        sys_rst,     // synchronous reset
    input  wire logic        key_step,    // advance/clear key, high pressed
    input  wire logic        key_prog,    // select key, high pressed
    input  wire logic [11:0] value_in,    // value for the green digits
    input  wire logic [11:0] edit_value,  // candidate setting value
    input  wire logic [11:0] limit_lo,    // lowest permitted setting
    input  wire logic [11:0] limit_hi,    // highest permitted setting
    input  wire logic        indicator,   // operation indicator mode request
    input  wire logic        edit_req,    // editing active elsewhere
    output logic [31:0]      seg_out,     // 8 segments per digit, digit 3 red
    output logic [3:0]       digit_en,    // digit enables, bit 3 is red
    output logic [7:0]       led_out,     // value LEDs, one per main item
    output logic [3:0]       main_pos,    // main menu position, 0 dark
    output logic [3:0]       sub_pos,     // submenu position, 0 none
    output logic [11:0]      stored_value,// last accepted setting
    output logic             store_pulse, // accepted store
    output logic             reject_pulse,// refused store
    output logic             ind_clear    // operation indicator reset pulse
);
    logic        tick_r;
    logic [31:0] pre_r;
    logic        s_held, s_long, s_short, s_rel;
    logic        p_held, p_long;
    panel_pkg::nav_state_t st_r;
    logic [7:0]  step_r;
    logic [15:0] tcnt_r;
    logic [31:0] idle_r;
    logic [7:0]  pause_r;
    logic [7:0]  flash_r;
    logic        flash_on_r;
    logic        both_r;

    // ============================================================
    // timebase
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_r  <= 32'h0;
            tick_r <= 1'b0;
        end else if (pre_r >= 32'(TICK_CYC - 1)) begin
            pre_r  <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            pre_r  <= pre_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // ============================================================
    // keys
    key_classifier u_step (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .tick      (tick_r),
        .key_raw   (key_step),
        .held      (s_held),
        .long_hit  (s_long),
        .short_rel (s_short),
        .released  (s_rel)
    );

    key_classifier u_prog (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .tick      (tick_r),
        .key_raw   (key_prog),
        .held      (p_held),
        .long_hit  (p_long),
        .short_rel (),
        .released  ()
    );

    wire both_now = s_held && p_held;
    wire both_evt = both_now && !both_r;
    wire fwd_ok   = s_long && !p_held && pause_r == 8'h00;
    wire back_ok  = s_short && !both_r && !p_held;
    wire in_lim   = edit_value >= limit_lo && edit_value <= limit_hi;

    // ============================================================
    // navigation state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r         <= panel_pkg::ST_TEST;
            main_pos     <= 4'h0;
            sub_pos      <= 4'h0;
            both_r       <= 1'b0;
            stored_value <= 12'h000;
            store_pulse  <= 1'b0;
            reject_pulse <= 1'b0;
            ind_clear    <= 1'b0;
            pause_r      <= 8'h00;
        end else begin
            both_r       <= both_now;
            store_pulse  <= 1'b0;
            reject_pulse <= 1'b0;
            ind_clear    <= 1'b0;
            if (tick_r && pause_r != 8'h00) begin
                pause_r <= pause_r - 8'h01;
            end
            case (st_r)
                panel_pkg::ST_TEST: begin
                    if (s_held || step_r >= 8'(`SELFTEST_STEPS)) begin
                        st_r <= panel_pkg::ST_DARK;
                    end
                end
                panel_pkg::ST_DARK: begin
                    if (s_rel && !s_short) begin
                        ind_clear <= 1'b1;
                    end
                    if (fwd_ok) begin
                        main_pos <= 4'h1;
                        st_r     <= panel_pkg::ST_MAIN;
                    end
                end
                panel_pkg::ST_MAIN: begin
                    if (idle_r >= 32'(IDLE_TICKS)) begin
                        main_pos <= 4'h0;
                        st_r     <= panel_pkg::ST_DARK;
                    end else if (edit_req && p_held) begin
                        st_r <= panel_pkg::ST_EDIT;
                    end else if (p_long) begin
                        sub_pos <= 4'h1;
                        st_r    <= panel_pkg::ST_SUB_HOLD;
                    end else if (fwd_ok) begin
                        if (main_pos >= 4'(MAIN_N)) begin
                            main_pos <= 4'h0;
                            pause_r  <= 8'(PAUSE_TICKS);
                            st_r     <= panel_pkg::ST_DARK;
                        end else begin
                            main_pos <= main_pos + 4'h1;
                        end
                    end else if (back_ok) begin
                        if (main_pos == 4'h1) begin
                            main_pos <= 4'h0;
                            st_r     <= panel_pkg::ST_DARK;
                        end else begin
                            main_pos <= main_pos - 4'h1;
                        end
                    end
                end
                panel_pkg::ST_SUB_HOLD: begin
                    if (!p_held) begin
                        st_r <= panel_pkg::ST_SUB;
                    end
                end
                panel_pkg::ST_SUB: begin
                    if (idle_r >= 32'(IDLE_TICKS)) begin
                        sub_pos  <= 4'h0;
                        main_pos <= 4'h0;
                        st_r     <= panel_pkg::ST_DARK;
                    end else if (edit_req && p_held) begin
                        st_r <= panel_pkg::ST_EDIT;
                    end else if (fwd_ok) begin
                        if (sub_pos >= 4'(SUB_N)) begin
                            sub_pos <= 4'h0;
                            st_r    <= panel_pkg::ST_MAIN;
                        end else begin
                            sub_pos <= sub_pos + 4'h1;
                        end
                    end else if (back_ok) begin
                        sub_pos <= sub_pos - 4'h1;
                        if (sub_pos == 4'h1) begin
                            st_r <= panel_pkg::ST_MAIN;
                        end
                    end
                end
                panel_pkg::ST_EDIT: begin
                    if (both_evt) begin
                        if (in_lim) begin
                            stored_value <= edit_value;
                            store_pulse  <= 1'b1;
                        end else begin
                            reject_pulse <= 1'b1;
                        end
                    end
                    if (!edit_req) begin
                        st_r <= (sub_pos != 4'h0) ? panel_pkg::ST_SUB : panel_pkg::ST_MAIN;
                    end
                end
                default: st_r <= panel_pkg::ST_DARK;
            endcase
        end
    end

    // ============================================================
    // self-test step counter and inactivity timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            step_r <= 8'h00;
            tcnt_r <= 16'h0000;
        end else if (st_r == panel_pkg::ST_TEST && tick_r) begin
            if (tcnt_r >= 16'(STEP_TICKS - 1)) begin
                tcnt_r <= 16'h0000;
                step_r <= step_r + 8'h01;
            end else begin
                tcnt_r <= tcnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_r <= 32'h0;
        end else if (s_held || st_r == panel_pkg::ST_DARK) begin
            idle_r <= 32'h0;
        end else if (tick_r && idle_r < 32'(IDLE_TICKS)) begin
            idle_r <= idle_r + 32'h1;
        end
    end

    // ============================================================
    // flashing of the red digit; restarts dark at release
    always_ff @(posedge mclk) begin
        if (sys_rst || st_r == panel_pkg::ST_SUB_HOLD) begin
            flash_r    <= 8'h00;
            flash_on_r <= 1'b0;
        end else if (tick_r) begin
            if (flash_r >= 8'(`FLASH_HALF_TICKS - 1)) begin
                flash_r    <= 8'h00;
                flash_on_r <= !flash_on_r;
            end else begin
                flash_r <= flash_r + 8'h01;
            end
        end
    end

    // ============================================================
    // display drive; a sweep is 21 outer steps (3 per segment) then 4 centre, bit 6
    logic [31:0] seg_nxt;
    logic [3:0]  den_nxt;
    logic [7:0]  led_nxt;
    logic [7:0]  sweep_pos;
    always_comb begin
        seg_nxt   = 32'h0;
        den_nxt   = 4'h0;
        led_nxt   = 8'h00;
        sweep_pos = 8'h00;
        case (st_r)
            panel_pkg::ST_TEST: begin
                sweep_pos = (step_r >= 8'd25) ? step_r - 8'd25 : step_r;
                den_nxt   = 4'hf;
                if (sweep_pos < 8'(`OUTER_SEGS * 3)) begin
                    for (int d = 0; d < `DIGITS; d++) begin
                        seg_nxt[d*8 + ((sweep_pos / 3) == 8'd6 ? 7 : 32'(sweep_pos / 3))]
                            = 1'b1;
                    end
                end else if (sweep_pos < 8'd25) begin
                    seg_nxt[32'(sweep_pos - 8'd21) * 8 + 6] = 1'b1;
                end
            end
            panel_pkg::ST_MAIN, panel_pkg::ST_EDIT: begin
                den_nxt = indicator ? 4'h8 : 4'hf;
                seg_nxt = {4'h0, main_pos, 12'h000, value_in};
                if (!indicator && main_pos != 4'h0) begin
                    led_nxt = 8'h01 << (main_pos - 4'h1);
                end
            end
            panel_pkg::ST_SUB_HOLD, panel_pkg::ST_SUB: begin
                den_nxt = {flash_on_r || st_r == panel_pkg::ST_SUB_HOLD, 3'b111};
                seg_nxt = {4'h0, sub_pos, 12'h000, value_in};
                if (main_pos != 4'h0 && main_pos <= 4'(MAIN_N)) begin
                    led_nxt = 8'h01 << (main_pos - 4'h1);
                end
            end
            default: begin
                den_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seg_out  <= 32'h0;
            digit_en <= 4'h0;
            led_out  <= 8'h00;
        end else begin
            seg_out  <= seg_nxt;
            digit_en <= den_nxt;
            led_out  <= led_nxt;
        end
    end
endmodule

// ==== hw/panel_params.svh ====
// timing constants, display layout and menu sizes for the front panel navigator
// assumes a 40 MHz module clock; included by the navigator and its key classifier
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

`define CLK_HZ              40000000
`define TICK_MS             10
`define TICK_CYCLES         ((`CLK_HZ / 1000) * `TICK_MS)
`define DEBOUNCE_MS         20
`define DEBOUNCE_TICKS      (`DEBOUNCE_MS / `TICK_MS)
`define BACK_HOLD_MS        500
`define BACK_HOLD_TICKS     (`BACK_HOLD_MS / `TICK_MS)
`define FWD_HOLD_MS         1000
`define FWD_HOLD_TICKS      (`FWD_HOLD_MS / `TICK_MS)
`define DARK_PAUSE_MS       2000
`define DARK_PAUSE_TICKS    (`DARK_PAUSE_MS / `TICK_MS)
`define IDLE_TIMEOUT_S      300
`define IDLE_TIMEOUT_TICKS  ((`IDLE_TIMEOUT_S * 1000) / `TICK_MS)
`define SELFTEST_S          15
`define SELFTEST_STEPS      50
`define SELFTEST_STEP_TICKS (((`SELFTEST_S * 1000) / `TICK_MS) / `SELFTEST_STEPS)
`define FLASH_HALF_MS       250
`define FLASH_HALF_TICKS    (`FLASH_HALF_MS / `TICK_MS)
`define MAIN_ITEMS          6
`define SUB_ITEMS           3
`define OUTER_SEGS          7
`define DIGITS              4
`define SWEEPS              2

`endif

// ==== hw/panel_pkg.sv ====
// types shared by the front panel navigator
// no constants here; they live in panel_params.svh
package panel_pkg;
    typedef enum logic [1:0] {
        KEY_NONE,
        KEY_BACK,
        KEY_FWD
    } key_evt_t;

    typedef enum logic [2:0] {
        ST_TEST,
        ST_DARK,
        ST_MAIN,
        ST_SUB_HOLD,
        ST_SUB,
        ST_EDIT
    } nav_state_t;
endpackage

// ==== hw/key_classifier.sv ====
// debounces one push button and classifies its hold time
// assumes tick is a one-cycle pulse from the navigator's prescaler
`timescale 1ns/1ps
`include "panel_params.svh"

module key_classifier #(
    parameter int DEB_TICKS  = `DEBOUNCE_TICKS,
    parameter int BACK_TICKS = `BACK_HOLD_TICKS,
    parameter int FWD_TICKS  = `FWD_HOLD_TICKS
) (
    input  wire logic mclk,     // module clock
    input  wire logic sys_rst,  // synchronous reset
    input  wire logic tick,     // timebase pulse
    input  wire logic key_raw,  // key level, high when pressed
    output logic      held,     // debounced level
    output logic      long_hit, // pulse when hold reaches forward time
    output logic      short_rel,// pulse on release after back time, before forward
    output logic      released  // pulse on any debounced release
);
    logic [7:0] deb_r;
    logic [7:0] hold_r;

    // ============================================================
    // debounce
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            deb_r <= 8'h00;
            held  <= 1'b0;
        end else if (key_raw == held) begin
            deb_r <= 8'h00;
        end else if (tick) begin
            if (deb_r >= 8'(DEB_TICKS - 1)) begin
                held  <= key_raw;
                deb_r <= 8'h00;
            end else begin
                deb_r <= deb_r + 8'h01;
            end
        end
    end

    // ============================================================
    // hold classification; repeats count from 256 - FWD_TICKS, so keep it under 128
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_r    <= 8'h00;
            long_hit  <= 1'b0;
            short_rel <= 1'b0;
            released  <= 1'b0;
        end else begin
            long_hit  <= 1'b0;
            short_rel <= 1'b0;
            released  <= 1'b0;
            if (!held) begin
                if (hold_r != 8'h00) begin
                    released  <= 1'b1;
                    short_rel <= hold_r >= 8'(BACK_TICKS) && hold_r < 8'(FWD_TICKS);
                end
                hold_r <= 8'h00;
            end else if (tick) begin
                if (hold_r == 8'(FWD_TICKS - 1) || hold_r == 8'hff) begin
                    long_hit <= 1'b1;
                    hold_r   <= 8'(256 - FWD_TICKS);
                end else begin
                    hold_r <= hold_r + 8'h01;
                end
            end
        end
    end
endmodule

// ==== test/panel_nav_chk.sv ====
// checker for the front panel navigator, watching only its ports
// assumes it is bound into panel_nav and shares mclk and sys_rst
`timescale 1ns/1ps
`include "panel_params.svh"

module panel_nav_chk #(
    parameter int TICK_CYC   = 4,
    parameter int IDLE_TICKS = 300,
    parameter int MAIN_N     = 6,
    parameter int SUB_N      = 3
) (
    input wire logic        mclk,         // module clock
    input wire logic        sys_rst,      // synchronous reset
    input wire logic        key_step,     // advance key
    input wire logic        key_prog,     // select key
    input wire logic [11:0] limit_lo,     // lowest setting
    input wire logic [11:0] limit_hi,     // highest setting
    input wire logic        indicator,    // indicator mode
    input wire logic        edit_req,     // editing active
    input wire logic [3:0]  digit_en,     // digit enables
    input wire logic [7:0]  led_out,      // value leds
    input wire logic [3:0]  main_pos,     // main position
    input wire logic [3:0]  sub_pos,      // sub position
    input wire logic [11:0] stored_value, // accepted setting
    input wire logic        store_pulse,  // accepted store
    input wire logic        reject_pulse  // refused store
);
    // margins cover debounce and register lag, not a slower design
    localparam int IDLE_LIM  = (IDLE_TICKS + 4) * TICK_CYC + 8;
    localparam int FLASH_LIM = `FLASH_HALF_TICKS * TICK_CYC + 8;
    int unsigned idle_cnt_r;
    int unsigned flash_cnt_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ====================
    // helper counters
    always_ff @(posedge mclk) begin
        if (sys_rst || key_step || key_prog || main_pos == 4'h0) begin
            idle_cnt_r <= 0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || sub_pos == 4'h0 || main_pos == 4'h0 || key_step || key_prog
            || edit_req || indicator || $changed(digit_en[3])) begin
            flash_cnt_r <= 0;
        end else begin
            flash_cnt_r <= flash_cnt_r + 1;
        end
    end

    // ====================
    // properties
    sequence s_left_dark;
        $past(main_pos) == 4'h0 ##0 main_pos != 4'h0;
    endsequence
    sequence s_both_held;
        key_step && key_prog;
    endsequence

    AST_DARK_FWD_ONLY: assert property (s_left_dark |-> main_pos == 4'h1)
        else $error("left dark to a position other than the first");
    AST_STEP_ONE: assert property (($past(main_pos) != 4'h0 && main_pos != 4'h0
        && $changed(main_pos)) |-> (main_pos == $past(main_pos) + 4'h1
        || main_pos == $past(main_pos) - 4'h1)) else $error("menu moved more than one place");
    AST_POS_RANGE: assert property (main_pos <= MAIN_N && sub_pos <= SUB_N)
        else $error("menu position out of range");
    AST_IND_ONLY_RED: assert property ((indicator && $past(indicator) && main_pos != 4'h0)
        |-> digit_en[2:0] == 3'h0 && led_out == 8'h00) else $error("indicator mode lit more");
    AST_LED_MATCH: assert property (($stable(main_pos) && main_pos != 4'h0 && !indicator
        && !$past(indicator)) |-> led_out == (8'h01 << (main_pos - 4'h1)))
        else $error("value led does not match position");
    AST_PULSE_CAUSE: assert property ((store_pulse || reject_pulse)
        |-> s_both_held ##0 !(store_pulse && reject_pulse)) else $error("store without both keys");
    AST_STORE_LIMITS: assert property (store_pulse
        |-> ##[0:1] (stored_value >= limit_lo && stored_value <= limit_hi))
        else $error("stored value outside limits");
    AST_REJECT_KEEP: assert property (reject_pulse
        |-> $stable(stored_value) ##1 $stable(stored_value)) else $error("refused value stored");
    AST_PULSE_ONE: assert property (store_pulse |=> !store_pulse && !reject_pulse)
        else $error("store pulse longer than one cycle");
    AST_IDLE_BOUND: assert property (idle_cnt_r <= IDLE_LIM)
        else $error("display stayed lit past the idle time");
    AST_FLASH: assert property (flash_cnt_r <= FLASH_LIM)
        else $error("red digit stopped flashing in submenu");
endmodule

bind panel_nav panel_nav_chk #(.TICK_CYC(TICK_CYC), .IDLE_TICKS(IDLE_TICKS),
    .MAIN_N(MAIN_N), .SUB_N(SUB_N)) panel_nav_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
    .key_step(key_step), .key_prog(key_prog), .limit_lo(limit_lo), .limit_hi(limit_hi),
    .indicator(indicator), .edit_req(edit_req), .digit_en(digit_en), .led_out(led_out),
    .main_pos(main_pos), .sub_pos(sub_pos), .stored_value(stored_value),
    .store_pulse(store_pulse), .reject_pulse(reject_pulse));

// ==== test/panel_operator.sv ====
// operator model: presses the two front keys for a number of ticks
// assumes keys read low when released, changes made at falling edges
`timescale 1ns/1ps

module panel_operator #(
    parameter int TICK_CYC = 4
) (
    input  wire logic mclk,     // module clock
    output logic      key_step, // advance key level
    output logic      key_prog  // select key level
);
    initial begin
        key_step = 1'b0;
        key_prog = 1'b0;
    end

    // ====================
    // one press with contact chatter that the debouncer must swallow
    task automatic press(input logic s, input logic p, input int ticks);
        repeat (3) begin
            @(negedge mclk);
            key_step <= s;
            key_prog <= p;
            @(negedge mclk);
            key_step <= 1'b0;
            key_prog <= 1'b0;
        end
        @(negedge mclk);
        key_step <= s;
        key_prog <= p;
        repeat (ticks * TICK_CYC) @(negedge mclk);
        key_step <= 1'b0;
        key_prog <= 1'b0;
        repeat (4 * TICK_CYC) @(negedge mclk);
    endtask
endmodule

// ==== test/panel_nav_test.sv ====
// self-checking bench for the front panel navigator
// assumes the operator model drives the keys and the checker is bound in
`timescale 1ns/1ps

module panel_nav_test;
    localparam int TC     = 4;
    localparam int IDLE   = 300;
    localparam int STEP   = 2;
    localparam int MAIN_N = 6;
    logic              mclk = 1'b0;
    logic              sys_rst;
    logic              key_step;
    logic              key_prog;
    logic              indicator;
    logic              edit_req;
    logic [11:0]       value_in, edit_value, limit_lo, limit_hi, stored_value, exp_val;
    logic [31:0]       seg_out;
    logic [3:0]        digit_en, main_pos, sub_pos, pos, pos_prev;
    logic [7:0]        led_out;
    logic              store_pulse, reject_pulse, ind_clear, red_prev, ok;
    logic [3:0]        pos_log[$];
    int                fail_count = 0;
    int                checks_done = 0;
    int                store_n = 0, reject_n = 0, clr_n = 0, flash_n = 0, s, r;

    always #12.5 mclk = ~mclk;

    panel_nav #(.TICK_CYC(TC), .IDLE_TICKS(IDLE), .STEP_TICKS(STEP), .PAUSE_TICKS(5))
    panel_nav_inst (.mclk(mclk), .sys_rst(sys_rst), .key_step(key_step),
        .key_prog(key_prog), .value_in(value_in), .edit_value(edit_value),
        .limit_lo(limit_lo), .limit_hi(limit_hi), .indicator(indicator),
        .edit_req(edit_req), .seg_out(seg_out), .digit_en(digit_en), .led_out(led_out),
        .main_pos(main_pos), .sub_pos(sub_pos), .stored_value(stored_value),
        .store_pulse(store_pulse), .reject_pulse(reject_pulse), .ind_clear(ind_clear));

    panel_operator #(.TICK_CYC(TC)) panel_operator_inst (.mclk(mclk),
        .key_step(key_step), .key_prog(key_prog));

    // ====================
    // monitors and helpers
    always @(negedge mclk) begin
        if (main_pos !== pos_prev) pos_log.push_back(main_pos);
        if (digit_en[3] !== red_prev) flash_n++;
        if (store_pulse === 1'b1) store_n++;
        if (reject_pulse === 1'b1) reject_n++;
        if (ind_clear === 1'b1) clr_n++;
        pos_prev <= main_pos;
        red_prev <= digit_en[3];
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [3:0] next_pos(input logic [3:0] p, input bit fwd);
        if (fwd) return (p == MAIN_N) ? 4'h0 : p + 4'h1;
        return (p == 4'h0) ? 4'h0 : p - 4'h1;
    endfunction

    // a forward step is a 110 tick hold, a backward step 70 ticks
    task automatic nav(input bit fwd);
        panel_operator_inst.press(1'b1, 1'b0, fwd ? 110 : 70);
        pos = next_pos(pos, fwd);
    endtask

    // ====================
    // scenarios
    initial begin
        void'($urandom(73473));
        sys_rst = 1'b1;
        value_in = 12'h000;
        edit_value = 12'h000;
        limit_lo = 12'($urandom_range(12'h400, 12'h100));
        limit_hi = 12'($urandom_range(12'hc00, 12'h800));
        indicator = 1'b0;
        edit_req = 1'b0;
        exp_val = 12'h000;
        pos = 4'h0;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (20) @(negedge mclk);
        check(digit_en != 4'h0, 1);
        check(seg_out, 32'h01010101);
        repeat (30 * STEP * TC - 20) @(negedge mclk);
        check(seg_out, 32'h02020202);
        repeat (18 * STEP * TC + 40) @(negedge mclk);
        check({main_pos, digit_en}, 8'h00);
        // second reset, then the advance key cuts the sweep short
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        panel_operator_inst.press(1'b1, 1'b0, 5);
        check(digit_en, 4'h0);
        s = clr_n;
        panel_operator_inst.press(1'b1, 1'b0, 20);
        check(clr_n - s, 1);
        nav(1'b0);
        check(main_pos, pos);
        for (int i = 0; i < 8; i++) begin
            value_in = 12'($urandom);
            nav((i < 2) || ($urandom_range(1, 0) == 1));
            check(main_pos, pos);
            if (pos != 4'h0) check(seg_out, {4'h0, pos, 12'h000, value_in});
        end
        if (pos == 4'h0) nav(1'b1);
        indicator = 1'b1;
        repeat (4) @(negedge mclk);
        check({digit_en, led_out}, {4'h8, 8'h00});
        indicator = 1'b0;
        repeat (4) @(negedge mclk);
        check(led_out, 8'h01 << (pos - 4'h1));
        repeat ((IDLE - 30) * TC) @(negedge mclk);
        check(main_pos, pos);
        repeat (40 * TC) @(negedge mclk);
        check({main_pos, digit_en}, 8'h00);
        // continuous hold walks the whole menu, pausing at dark
        pos_log.delete();
        panel_operator_inst.press(1'b1, 1'b0, 1000);
        for (int i = 0; i < 8; i++) check(pos_log[i], (i == 7) ? 1 : (i + 1) % 7);
        repeat ((IDLE + 40) * TC) @(negedge mclk);
        pos = 4'h0;
        check(main_pos, pos);
        nav(1'b1);
        nav(1'b1);
        panel_operator_inst.press(1'b0, 1'b1, 110);
        check(sub_pos, 4'h1);
        check(led_out, 8'h02);
        s = flash_n;
        repeat (60 * TC) @(negedge mclk);
        check(flash_n - s >= 2, 1);
        panel_operator_inst.press(1'b1, 1'b0, 110);
        check(sub_pos, 4'h2);
        panel_operator_inst.press(1'b1, 1'b0, 70);
        check({main_pos, sub_pos}, 8'h21);
        // stores at both limits, just outside them and at random inside
        edit_req = 1'b1;
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: edit_value = limit_lo;
                1: edit_value = limit_hi + 12'h001;
                2: edit_value = limit_hi;
                3: edit_value = limit_lo - 12'h001;
                default: edit_value = 12'($urandom_range(limit_hi, limit_lo));
            endcase
            ok = (edit_value >= limit_lo) && (edit_value <= limit_hi);
            s = store_n;
            r = reject_n;
            panel_operator_inst.press(1'b0, 1'b1, 10);
            panel_operator_inst.press(1'b1, 1'b1, 10);
            check(store_n - s, ok);
            check(reject_n - r, !ok);
            if (ok) exp_val = edit_value;
            check(stored_value, exp_val);
        end
        edit_req = 1'b0;
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        stop_test();
    end
endmodule
